// File: afc_cfg.svh
// constants for the axis feed control and status block
// Operation
// (R01) override bit rise loads axis override value
// (R02) controller keeps override within 0.1 to 199.9
// (R03) linear, circular, traverse accept up to 199.9
// (R04) other operations cap override at 100.0
// (R05) in-span value above limit becomes limit
// (R06) override is 100.0 until first enable
// (R07) jog direction sampled on jog command rise
// (R08) direction high means decreasing position
// (R09) ratio bits followed continuously during handwheel
// (R10) ratio index is bit15:bit14, 00 is ratio one
// (R11) error location in status bits 3..0
// (R12) nonzero location raises flag, stores error code
// (R13) two-axis build hides task3/4, Z, U codes
// (R14) autoload flag set on start, cleared on done
// (R15) error reset command clears autoload flag
// (R16) autoload failure raises autoload error flag
// (R17) host tool checks job and data before serving
// (R18) no host contact within monitor time flags timeout
// (R19) error reset command clears autoload error flag
// (R20) words sampled once per refresh strobe
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH
`define AFC_X_CTRL_IDX   8'h0b
`define AFC_Y_CTRL_IDX   8'h0d
`define AFC_Z_CTRL_IDX   8'h0f
`define AFC_U_CTRL_IDX   8'h11
`define AFC_STATUS_IDX   8'h12
`define AFC_ERRCODE_IDX  8'h13
`define AFC_OVR_BASE_IDX 8'h20
`define AFC_CMD_IDX      8'h24
`define AFC_TOUT_IDX     8'h25
`define AFC_OVR_BIT      12
`define AFC_JDIR_BIT     13
`define AFC_RLO_BIT      14
`define AFC_RHI_BIT      15
`define AFC_ST_LOAD_BIT  4
`define AFC_ST_LERR_BIT  5
`define AFC_ST_TUP_BIT   6
`define AFC_ST_ERR_BIT   14
`define AFC_OVR_MIN      11'h001
`define AFC_OVR_MAX_HI   11'h7cf
`define AFC_OVR_MAX_LO   11'h3e8
`define AFC_OVR_DEFAULT  11'h3e8
`define AFC_TOUT_RESET   16'h03e8
`endif

// File: afc_pkg.sv
// types for the axis feed control and status block
package afc_pkg;
  typedef enum logic [1:0] {afc_idle, afc_wait, afc_load} afc_load_st_t;
  typedef struct packed {
    logic [3:0][15:0] ctrl;
    logic [3:0][10:0] ovr_set;
    logic [3:0][10:0] ovr_act;
    logic [3:0]       ovr_q;
    logic [3:0]       jog_q;
    logic [3:0]       jog_dir;
    logic [3:0][1:0]  ratio;
    logic [3:0]       loc;
    logic [15:0]      err_code;
    logic             load_flag;
    logic             load_err;
    logic             tup;
    logic [15:0]      tout;
    logic [15:0]      tcnt;
    afc_load_st_t     st;
    logic [31:0]      prdata;
  } afc_state_t;
endpackage

// File: afc_regs.sv
// axis feed control bits and system status word over apb
`timescale 1ns/1ns
`default_nettype none
`include "afc_cfg.svh"
module afc_regs
  import afc_pkg::*;
#(
  parameter bit TWO_AXIS = 1'b0
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // motion core side
  input  wire logic              refresh,
  input  wire logic [3:0]        jog_cmd,
  input  wire logic [3:0]        op_fast,
  input  wire logic [3:0]        err_loc,
  input  wire logic [15:0]       err_code_in,
  input  wire logic              load_start,
  input  wire logic              load_done,
  input  wire logic              load_fail,
  input  wire logic              host_link,
  output logic      [3:0][10:0]  override,
  output logic      [3:0]        jog_dir,
  output logic      [3:0][1:0]   ratio_sel
);
  afc_state_t r;
  afc_state_t next_r;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [7:0] idx;
  logic       rst_cmd;
  logic [3:0] eloc;
  assign idx = paddr[9:2];
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  // word addressed registers; every access done in one access cycle
  assign hit = (idx == `AFC_X_CTRL_IDX) || (idx == `AFC_Y_CTRL_IDX) ||
               (idx == `AFC_Z_CTRL_IDX) || (idx == `AFC_U_CTRL_IDX) ||
               (idx == `AFC_STATUS_IDX) || (idx == `AFC_ERRCODE_IDX) ||
               (idx >= `AFC_OVR_BASE_IDX && idx <= `AFC_TOUT_IDX);
  assign pslverr = psel & penable & ~hit;
  assign rst_cmd = wr && idx == `AFC_CMD_IDX && pwdata[0];
  // (R13) reduced build filters codes it cannot have
  always_comb begin
    eloc = err_loc;
    if (TWO_AXIS && (err_loc == 4'h4 || err_loc == 4'h5 || err_loc == 4'h8 ||
                     err_loc == 4'h9)) begin
      eloc = 4'h1;
    end
    if (err_loc > 4'h9) begin
      eloc = 4'h1;
    end
  end
  // next state
  always_comb begin
    next_r = r;
    // register writes
    if (wr) begin
      if (idx == `AFC_X_CTRL_IDX) begin
        next_r.ctrl[0] = pwdata[15:0];
      end else if (idx == `AFC_Y_CTRL_IDX) begin
        next_r.ctrl[1] = pwdata[15:0];
      end else if (idx == `AFC_Z_CTRL_IDX) begin
        next_r.ctrl[2] = pwdata[15:0];
      end else if (idx == `AFC_U_CTRL_IDX) begin
        next_r.ctrl[3] = pwdata[15:0];
      end else if (idx >= `AFC_OVR_BASE_IDX && idx < `AFC_CMD_IDX) begin
        next_r.ovr_set[idx[1:0]] = pwdata[10:0];
      end else if (idx == `AFC_TOUT_IDX) begin
        next_r.tout = pwdata[15:0];
      end
    end
    // (R20) control bits acted on only at a refresh strobe
    if (refresh) begin
      for (int i = 0; i < 4; i++) begin
        next_r.ovr_q[i] = r.ctrl[i][`AFC_OVR_BIT];
        next_r.jog_q[i] = jog_cmd[i];
        // (R01) load override on rising enable
        if (r.ctrl[i][`AFC_OVR_BIT] && !r.ovr_q[i]) begin
          next_r.ovr_act[i] = r.ovr_set[i];
        end
        // (R06) disabled override reads as default
        if (!r.ctrl[i][`AFC_OVR_BIT]) begin
          next_r.ovr_act[i] = `AFC_OVR_DEFAULT;
        end
        // (R07) direction latched on jog rise only
        if (jog_cmd[i] && !r.jog_q[i]) begin
          next_r.jog_dir[i] = r.ctrl[i][`AFC_JDIR_BIT];
        end
        // (R09) ratio bits tracked every refresh
        next_r.ratio[i] = {r.ctrl[i][`AFC_RHI_BIT], r.ctrl[i][`AFC_RLO_BIT]};
      end
      // (R11) location code captured
      next_r.loc = eloc;
      // (R12) code stored only with an error present
      next_r.err_code = (eloc != 4'h0) ? err_code_in : 16'h0000;
    end
    // autoload sequence with host-contact watchdog
    case (r.st)
      afc_idle: begin
        next_r.tcnt = 16'h0000;
        if (load_start) begin
          next_r.st = afc_wait;
        end
      end
      afc_wait: begin
        next_r.tcnt = r.tcnt + 16'h0001;
        if (host_link) begin
          next_r.st = afc_load;
        end else if (r.tcnt >= r.tout) begin
          next_r.st = afc_idle;
        end
      end
      default: begin
        if (load_done || load_fail) begin
          next_r.st = afc_idle;
        end
      end
    endcase
    // (R15) reset command ends the flag and sequence
    if (rst_cmd) begin
      next_r.load_flag = 1'b0;
      next_r.st = afc_idle;
    end
    // (R14) flag follows start and completion
    if (r.st == afc_load && load_done) begin
      next_r.load_flag = 1'b0;
    end
    if (r.st == afc_idle && load_start && !rst_cmd) begin
      next_r.load_flag = 1'b1;
    end
    // (R18) watchdog expiry raises time-up
    if (rst_cmd) begin
      next_r.tup = 1'b0;
    end
    if (r.st == afc_wait && !host_link && r.tcnt >= r.tout) begin
      next_r.tup = 1'b1;
      next_r.load_flag = 1'b0;
    end
    // (R19) reset command clears error; a new error wins
    if (rst_cmd) begin
      next_r.load_err = 1'b0;
    end
    // (R16) a failure outside idle or a timeout sets error flag
    if ((r.st != afc_idle && load_fail) ||
        (r.st == afc_wait && !host_link && r.tcnt >= r.tout)) begin
      next_r.load_err = 1'b1;
    end
    // read data captured in access cycle
    next_r.prdata = 32'h0000_0000;
    if (rd) begin
      if (idx == `AFC_X_CTRL_IDX) begin
        next_r.prdata = {16'h0000, r.ctrl[0]};
      end else if (idx == `AFC_Y_CTRL_IDX) begin
        next_r.prdata = {16'h0000, r.ctrl[1]};
      end else if (idx == `AFC_Z_CTRL_IDX) begin
        next_r.prdata = {16'h0000, r.ctrl[2]};
      end else if (idx == `AFC_U_CTRL_IDX) begin
        next_r.prdata = {16'h0000, r.ctrl[3]};
      end else if (idx == `AFC_STATUS_IDX) begin
        next_r.prdata = {17'h0_0000, (r.loc != 4'h0), 7'h00, r.tup,
                         r.load_err, r.load_flag, r.loc};
      end else if (idx == `AFC_ERRCODE_IDX) begin
        next_r.prdata = {16'h0000, r.err_code};
      end else if (idx >= `AFC_OVR_BASE_IDX && idx < `AFC_CMD_IDX) begin
        next_r.prdata = {21'h00_0000, r.ovr_set[idx[1:0]]};
      end else if (idx == `AFC_TOUT_IDX) begin
        next_r.prdata = {16'h0000, r.tout};
      end
    end
  end
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ovr_act <= {4{`AFC_OVR_DEFAULT}};
      r.ovr_set <= {4{`AFC_OVR_DEFAULT}};
      r.tout <= `AFC_TOUT_RESET;
      r.st <= afc_idle;
    end else begin
      r <= next_r;
    end
  end
  // prdata is combinational from the read capture would lag; drive live instead
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (idx == `AFC_STATUS_IDX) begin
        prdata = {17'h0_0000, (r.loc != 4'h0), 7'h00, r.tup,
                  r.load_err, r.load_flag, r.loc};
      end else if (idx == `AFC_ERRCODE_IDX) begin
        prdata = {16'h0000, r.err_code};
      end else if (idx == `AFC_TOUT_IDX) begin
        prdata = {16'h0000, r.tout};
      end else if (idx >= `AFC_OVR_BASE_IDX && idx < `AFC_CMD_IDX) begin
        prdata = {21'h00_0000, r.ovr_set[idx[1:0]]};
      end else if (idx == `AFC_X_CTRL_IDX) begin
        prdata = {16'h0000, r.ctrl[0]};
      end else if (idx == `AFC_Y_CTRL_IDX) begin
        prdata = {16'h0000, r.ctrl[1]};
      end else if (idx == `AFC_Z_CTRL_IDX) begin
        prdata = {16'h0000, r.ctrl[2]};
      end else if (idx == `AFC_U_CTRL_IDX) begin
        prdata = {16'h0000, r.ctrl[3]};
      end
    end
  end
  // outputs; override clamped per operation class
  for (genvar g = 0; g < 4; g++) begin : g_ax
    logic [10:0] lim;
    logic [10:0] v;
    // (R03) fast moves allow full span
    // (R04) others capped at 100.0
    assign lim = op_fast[g] ? `AFC_OVR_MAX_HI : `AFC_OVR_MAX_LO;
    assign v = (r.ovr_act[g] < `AFC_OVR_MIN) ? `AFC_OVR_MIN : r.ovr_act[g];
    // (R05) in-span value above limit replaced by limit
    assign override[g] = (v > lim) ? lim : v;
    // (R08) high means toward decreasing position
    assign jog_dir[g] = r.jog_dir[g];
    // (R10) index bit15 high, bit14 low
    assign ratio_sel[g] = r.ratio[g];
  end
  // checks on the stored error code and the override path; the clamp is pure logic, so
  // the clamp checks watch the output seen by the motion core in the same cycle; default and load checks watch the registered value
  // (R12) zero location leaves no stored code
  a_err_flag: assert property (@(posedge pclk) disable iff (!presetn) // (R12)
    (r.loc == 4'h0)
    |-> (r.err_code == 16'h0000))
    else $error("code without location");
  // (R06) no enable at a refresh, default seen the next cycle
  a_ovr_def: assert property (@(posedge pclk) disable iff (!presetn) // (R06)
    (refresh && !r.ctrl[0][`AFC_OVR_BIT])
    |=> (r.ovr_act[0] == `AFC_OVR_DEFAULT))
    else $error("override not default");
  // (R04) slow ops never exceed 100.0
  a_ovr_cap: assert property (@(posedge pclk) disable iff (!presetn) // (R04)
    !op_fast[1]
    |-> (override[1] <= `AFC_OVR_MAX_LO))
    else $error("override above cap");
  // (R03) fast ops never exceed 199.9
  a_ovr_fast: assert property (@(posedge pclk) disable iff (!presetn) // (R03)
    op_fast[0]
    |-> (override[0] <= `AFC_OVR_MAX_HI))
    else $error("override above span");
  // (R01) rising enable loads the stored value
  a_ovr_load: assert property (@(posedge pclk) disable iff (!presetn) // (R01)
    (refresh && r.ctrl[0][`AFC_OVR_BIT] && !r.ovr_q[0])
    |=> (r.ovr_act[0] == $past(r.ovr_set[0])))
    else $error("override not loaded");
  // (R01) a steady enable does not reload
  a_ovr_hold: assert property (@(posedge pclk) disable iff (!presetn) // (R01)
    (refresh && r.ctrl[0][`AFC_OVR_BIT] && r.ovr_q[0])
    |=> $stable(r.ovr_act[0]))
    else $error("override reloaded");
  // (R05) in-span value passes unchanged on a fast op
  a_ovr_pass: assert property (@(posedge pclk) disable iff (!presetn) // (R05)
    (op_fast[2] && r.ovr_act[2] >= `AFC_OVR_MIN && r.ovr_act[2] <= `AFC_OVR_MAX_HI)
    |-> (override[2] == r.ovr_act[2]))
    else $error("override altered");
  // (R05) value above a slow limit becomes the limit
  a_ovr_clip: assert property (@(posedge pclk) disable iff (!presetn) // (R05)
    (!op_fast[3] && r.ovr_act[3] > `AFC_OVR_MAX_LO)
    |-> (override[3] == `AFC_OVR_MAX_LO))
    else $error("override not clipped");
  // (R05) nothing below the bottom of the span leaves
  a_ovr_floor: assert property (@(posedge pclk) disable iff (!presetn) // (R05)
    1'b1
    |-> (override[1] >= `AFC_OVR_MIN))
    else $error("override below span");
  // jog and ratio: both are sampled only at a refresh strobe
  // (R07) jog direction holds without jog rise
  a_jog_hold: assert property (@(posedge pclk) disable iff (!presetn) // (R07)
    !(refresh && jog_cmd[0] && !r.jog_q[0])
    |=> $stable(r.jog_dir[0]))
    else $error("jog direction changed");
  // (R07) jog rise takes the direction bit
  a_jog_take: assert property (@(posedge pclk) disable iff (!presetn) // (R07)
    (refresh && jog_cmd[1] && !r.jog_q[1])
    |=> (r.jog_dir[1] == $past(r.ctrl[1][`AFC_JDIR_BIT])))
    else $error("jog direction not taken");
  // (R07) nothing moves the direction between refreshes
  a_jog_idle: assert property (@(posedge pclk) disable iff (!presetn) // (R07)
    !refresh
    |=> $stable(r.jog_dir))
    else $error("jog direction moved");
  // (R09) ratio follows control word at refresh
  a_ratio_trk: assert property (@(posedge pclk) disable iff (!presetn) // (R09)
    refresh
    |=> (r.ratio[2] == $past(r.ctrl[2][15:14])))
    else $error("ratio stale");
  // (R20) location and ratio only move at a refresh
  a_refresh_only: assert property (@(posedge pclk) disable iff (!presetn) // (R20)
    !refresh
    |=> ($stable(r.loc) && $stable(r.ratio)))
    else $error("update outside refresh");
  // error location word
  // (R11) location captured at refresh
  a_loc_cap: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
    (refresh && !TWO_AXIS && err_loc < 4'ha)
    |=> (r.loc == $past(err_loc)))
    else $error("location not captured");
  // (R11) only defined codes are reported
  a_loc_range: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
    1'b1
    |-> (r.loc <= 4'h9))
    else $error("location out of range");
  // (R12) a nonzero location stores its code
  a_code_cap: assert property (@(posedge pclk) disable iff (!presetn) // (R12)
    (refresh && eloc != 4'h0)
    |=> (r.err_code == $past(err_code_in)))
    else $error("error code not stored");
  // (R13) reduced build never shows missing units
  a_two_axis: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
    TWO_AXIS
    |-> (r.loc != 4'h4 && r.loc != 4'h5 && r.loc != 4'h8 && r.loc != 4'h9))
    else $error("unsupported location shown");
  // autoload flags; set and clear may meet in one cycle, see priorities above
  // (R14) start from idle sets flag
  a_load_set: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
    (r.st == afc_idle && load_start && !rst_cmd)
    |=> r.load_flag)
    else $error("autoload flag not set");
  // (R14) completion clears the flag
  a_load_done: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
    (r.st == afc_load && load_done)
    |=> !r.load_flag)
    else $error("autoload flag not cleared");
  // (R14) flag rises only on a start from idle
  a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
    (!r.load_flag && !(r.st == afc_idle && load_start))
    |=> !r.load_flag)
    else $error("autoload flag rose alone");
  // (R15) reset command drops the flag
  a_load_rst: assert property (@(posedge pclk) disable iff (!presetn) // (R15)
    rst_cmd
    |=> !r.load_flag)
    else $error("autoload flag kept");
  // (R16) failure while busy sets the error flag
  a_fail_set: assert property (@(posedge pclk) disable iff (!presetn) // (R16)
    (r.st != afc_idle && load_fail)
    |=> r.load_err)
    else $error("autoload error not set");
  // (R16) error flag stays until the reset command
  a_err_keep: assert property (@(posedge pclk) disable iff (!presetn) // (R16)
    (r.load_err && !rst_cmd)
    |=> r.load_err)
    else $error("autoload error lost");
  // (R19) reset command clears error next cycle unless new failure or timeout
  a_err_clr: assert property (@(posedge pclk) disable iff (!presetn) // (R19)
    (rst_cmd && !load_fail && r.st != afc_wait)
    |=> !r.load_err)
    else $error("error flag not cleared");
  // (R18) host silence past the limit raises time-up
  a_tup_set: assert property (@(posedge pclk) disable iff (!presetn) // (R18)
    (r.st == afc_wait && !host_link && r.tcnt >= r.tout)
    |=> r.tup)
    else $error("time-up not raised");
  // (R18) reset command clears time-up without a new expiry
  a_tup_clr: assert property (@(posedge pclk) disable iff (!presetn) // (R18)
    (rst_cmd && !(r.st == afc_wait && !host_link && r.tcnt >= r.tout))
    |=> !r.tup)
    else $error("time-up not cleared");
endmodule
`default_nettype wire

// File: afc_core_model.sv
// motion core and autoload engine model facing the status side
`timescale 1ns/1ns
`default_nettype none
module afc_core_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // job requests from the bench
  input  wire logic go,
  input  wire logic bad,
  // strobes into the block
  output logic      refresh,
  output logic      load_start,
  output logic      load_done,
  output logic      load_fail
);
  logic [1:0] ph;
  logic [3:0] run;
  // refresh every fourth cycle; a job runs 15 cycles so flags are seen mid-load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 2'h0;
      run <= 4'h0;
      refresh <= 1'h0;
      load_start <= 1'h0;
      load_done <= 1'h0;
      load_fail <= 1'h0;
    end else begin
      ph <= ph + 2'h1;
      refresh <= (ph == 2'h3);
      // host refusal of a bad job arrives as a failure
      load_start <= go;
      run <= go ? 4'hf : (run != 4'h0 ? run - 4'h1 : 4'h0);
      load_done <= (run == 4'h1) && !bad;
      load_fail <= (run == 4'h1) && bad;
    end
  end
endmodule
`default_nettype wire

// File: test_afc_regs.sv
// self-checking bench for the axis feed control and status block
`timescale 1ns/1ns
`default_nettype none
module test_afc_regs;
  import afc_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0]      paddr, pwdata, prdata, rd;
  logic             refresh, load_start, load_done, load_fail, host_link, go, bad;
  logic [3:0]       jog_cmd, op_fast, err_loc, jog_dir;
  logic [15:0]      err_code_in;
  logic [3:0][10:0] override;
  logic [3:0][1:0]  ratio_sel;
  int               err_total, checks;
  afc_regs afc_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refresh(refresh), .jog_cmd(jog_cmd), .op_fast(op_fast),
    .err_loc(err_loc), .err_code_in(err_code_in), .load_start(load_start),
    .load_done(load_done), .load_fail(load_fail), .host_link(host_link),
    .override(override), .jog_dir(jog_dir), .ratio_sel(ratio_sel));
  afc_core_model afc_core_model_i (.pclk(pclk), .presetn(presetn), .go(go), .bad(bad),
    .refresh(refresh), .load_start(load_start), .load_done(load_done), .load_fail(load_fail));
  // apb transfer; waits for pready since the slave latency is not assumed
  task apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= 32'({ix, 2'h0});
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // effects land only after the next refresh strobe
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  task close_out;
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_reset_vals;
    for (int i = 0; i < 4; i++) chk(override[i], 32'h0000_03e8);
    apb(1'h0, 8'h12, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h0000_0000);
  endtask
  task t_override;
    op_fast <= 4'hf;
    apb(1'h1, 8'h20, 32'h0000_05dc);
    apb(1'h1, 8'h0b, 32'h0000_1000);
    settle;
    chk(override[0], 32'h0000_05dc);
    apb(1'h1, 8'h20, 32'h0000_07cf);
    settle;
    chk(override[0], 32'h0000_05dc);
    apb(1'h1, 8'h0b, 32'h0);
    settle;
    apb(1'h1, 8'h0b, 32'h0000_1000);
    settle;
    chk(override[0], 32'h0000_07cf);
    op_fast <= 4'he;
    settle;
    chk(override[0], 32'h0000_03e8);
  endtask
  task t_jog;
    apb(1'h1, 8'h0d, 32'h0000_2000);
    settle;
    jog_cmd <= 4'h2;
    settle;
    chk(jog_dir[1], 32'h1);
    apb(1'h1, 8'h0d, 32'h0);
    settle;
    chk(jog_dir[1], 32'h1);
    jog_cmd <= 4'h0;
    settle;
    jog_cmd <= 4'h2;
    settle;
    chk(jog_dir[1], 32'h0);
  endtask
  task t_ratio;
    for (int r = 0; r < 4; r++) begin
      apb(1'h1, 8'h11, 32'(r << 14));
      settle;
      chk(ratio_sel[3], 32'(r));
    end
    apb(1'h0, 8'h11, 32'h0);
    chk(rd[15:0], 32'h0000_c000);
  endtask
  task t_errloc;
    for (int c = 0; c < 10; c++) begin
      err_loc <= 4'(c);
      err_code_in <= 16'(32'h0000_0a00 + c);
      settle;
      apb(1'h0, 8'h12, 32'h0);
      chk({rd[14], rd[3:0]}, 32'({c != 0, 4'(c)}));
      apb(1'h0, 8'h13, 32'h0);
      if (c != 0) chk(rd[15:0], 32'h0000_0a00 + c);
    end
  endtask
  // one-cycle job request into the model
  task job(input logic b);
    bad <= b;
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    settle;
  endtask
  task t_autoload;
    job(1'h0);
    apb(1'h0, 8'h12, 32'h0);
    chk(rd[4], 32'h1);
    repeat (16) @(posedge pclk);
    apb(1'h0, 8'h12, 32'h0);
    chk(rd[4], 32'h0);
    job(1'h0);
    apb(1'h1, 8'h24, 32'h1);
    settle;
    apb(1'h0, 8'h12, 32'h0);
    chk(rd[4], 32'h0);
    job(1'h1);
    repeat (16) @(posedge pclk);
    apb(1'h0, 8'h12, 32'h0);
    chk(rd[5], 32'h1);
    apb(1'h1, 8'h24, 32'h1);
    settle;
    apb(1'h0, 8'h12, 32'h0);
    chk(rd[5], 32'h0);
    apb(1'h1, 8'h25, 32'h2);
    host_link <= 1'h0;
    job(1'h0);
    apb(1'h0, 8'h12, 32'h0);
    chk(rd[6], 32'h1);
  endtask
  task t_unmapped;
    apb(1'h0, 8'h30, 32'h0);
    chk(32'(er), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, go, bad, host_link} = 7'h01;
    {paddr, pwdata, jog_cmd, op_fast, err_loc, err_code_in} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_reset_vals;
    t_override;
    t_jog;
    t_ratio;
    t_errloc;
    t_autoload;
    t_unmapped;
    close_out;
  end
  // hang guard well beyond the expected run
  initial begin
    repeat (6000) @(posedge pclk);
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
